// ---- rtl/sdl_pkg.sv ----
// Purpose: shared constants and types for the sdram latency pair
// Assumes: one 40 MHz clock, both ends on it
// Notes: cycle counts derive from the ns figures and the period
// Behaviour
// - low clock enable freezes device one cycle later
// - read mask floats outputs two cycles later
// - write mask blocks the same-edge data word
// - first write word rides with write command
// - command decoded on the chip-select edge
// - precharge floats read outputs after cas latency
// - precharge: last word one before float
// - burst stop floats read outputs after cas latency
// - burst stop: last word one before float
// - read autoprecharge waits burst plus precharge
// - write autoprecharge waits burst+1 plus precharge
// - ns times round up to whole cycles
package sdl_pkg;
    // ****************************************************
    // widths
    // ****************************************************
    localparam int DW = 16;
    localparam int ADDR_W = 12;
    localparam int COL_W = 4;
    localparam int AP_BIT = 10;
    localparam int BL = 4;
    localparam int BLW = 2;
    localparam int MEM_D = 16;
    localparam int FIFO_DEPTH = 2;
    localparam int FW = BL * (DW + 1);
    // ****************************************************
    // latencies in cycles
    // ****************************************************
    localparam int CL2 = 2;
    localparam int CL3 = 3;
    localparam int CL_MAX = 3;
    localparam int RD_DQM_LAT = 2;
    // ****************************************************
    // timing
    // ****************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_RP_NS = 20;
    localparam int T_RCD_NS = 20;
    // round up to whole cycles
    localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ****************************************************
    // command codes as {ras_n, cas_n, we_n}
    // ****************************************************
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_BST = 3'h6;
    // ****************************************************
    // types
    // ****************************************************
    typedef logic [3:0] sdl_cnt_t;
    typedef logic [BLW-1:0] sdl_bix_t;
    typedef logic [COL_W-1:0] sdl_col_t;
    typedef enum logic [1:0] {CUT_NONE, CUT_PRE, CUT_BST} sdl_cut_t;
    typedef enum logic [1:0] {CS_IDLE, CS_RCD, CS_BURST} sdl_cst_t;
endpackage

// ---- rtl/sdl_if.sv ----
// Purpose: pin bundle between controller and sdram end
// Assumes: both ends clocked by the same clock
// Notes: dq level resolved here from the two enables
`timescale 1ns/10ps
interface sdl_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic dqm;
    logic [sdl_pkg::ADDR_W-1:0] addr;
    logic [sdl_pkg::DW-1:0] ctl_dq;
    logic ctl_dq_oe;
    logic [sdl_pkg::DW-1:0] dev_dq;
    logic dev_dq_oe;
    logic [sdl_pkg::DW-1:0] dq;

    // floating bus reads as zero; oe tells who drives
    assign dq = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : '0);

    modport ctl (
        output cke, cs_n, ras_n, cas_n, we_n, dqm, addr,
        output ctl_dq, ctl_dq_oe,
        input dq, dev_dq_oe
    );
    modport dev (
        input cke, cs_n, ras_n, cas_n, we_n, dqm, addr, dq,
        output dev_dq, dev_dq_oe
    );
endinterface

// ---- rtl/sdl_dev.sv ----
// Purpose: sdram end, command and data latency behaviour
// Assumes: pins come from logic on the same clock
// Notes: row and bank ignored; column picks a word
`timescale 1ns/10ps
module sdl_dev (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // configuration
    input wire logic cl3_i,
    // pins
    sdl_if.dev pin
);
    // ****************************************************
    // state
    // ****************************************************
    logic act_ff, nxt_act;
    logic rd_on_ff, nxt_rd_on;
    logic wr_on_ff, nxt_wr_on;
    sdl_pkg::sdl_col_t col_ff, nxt_col;
    sdl_pkg::sdl_cnt_t left_ff, nxt_left;
    logic [sdl_pkg::CL_MAX-1:0] pv_ff, nxt_pv;
    logic [sdl_pkg::DW-1:0] pd_ff [sdl_pkg::CL_MAX];
    logic [sdl_pkg::DW-1:0] nxt_pd [sdl_pkg::CL_MAX];
    logic [sdl_pkg::RD_DQM_LAT-1:0] dqm_sh_ff, nxt_dqm_sh;
    logic [sdl_pkg::DW-1:0] dq_ff, nxt_dq;
    logic oe_ff, nxt_oe;
    logic [sdl_pkg::DW-1:0] mem [sdl_pkg::MEM_D];
    logic wen;
    sdl_pkg::sdl_col_t ucol;
    logic issue;
    logic cmd_v;
    logic [2:0] cmd;
    int sel;

    assign pin.dev_dq = dq_ff;
    assign pin.dev_dq_oe = oe_ff;

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        nxt_act = pin.cke;
        nxt_rd_on = rd_on_ff;
        nxt_wr_on = wr_on_ff;
        nxt_col = col_ff;
        nxt_left = left_ff;
        nxt_pv = pv_ff;
        nxt_pd = pd_ff;
        nxt_dqm_sh = dqm_sh_ff;
        nxt_dq = dq_ff;
        nxt_oe = oe_ff;
        wen = 1'b0;
        issue = 1'b0;
        ucol = col_ff;
        // command is live on the edge that sees cs low
        cmd_v = !pin.cs_n;
        cmd = {pin.ras_n, pin.cas_n, pin.we_n};
        sel = cl3_i ? sdl_pkg::CL3 - 1 : sdl_pkg::CL2 - 1;
        // frozen one edge after cke is seen low
        if (act_ff) begin
            // mask taken now acts on the output two edges on
            nxt_dqm_sh = {dqm_sh_ff[0], pin.dqm};
            nxt_dq = pd_ff[sel];
            nxt_oe = pv_ff[sel] & ~dqm_sh_ff[sdl_pkg::RD_DQM_LAT-1];
            if (cmd_v && cmd == sdl_pkg::CMD_RD) begin
                ucol = pin.addr[sdl_pkg::COL_W-1:0];
                issue = 1'b1;
                nxt_rd_on = 1'b1;
                nxt_wr_on = 1'b0;
                nxt_left = sdl_pkg::sdl_cnt_t'(sdl_pkg::BL - 1);
            end else if (cmd_v && cmd == sdl_pkg::CMD_WR) begin
                ucol = pin.addr[sdl_pkg::COL_W-1:0];
                // first word taken on the command edge
                wen = !pin.dqm;
                nxt_rd_on = 1'b0;
                nxt_wr_on = 1'b1;
                nxt_left = sdl_pkg::sdl_cnt_t'(sdl_pkg::BL - 1);
            end else if (cmd_v && (cmd == sdl_pkg::CMD_PRE ||
                                   cmd == sdl_pkg::CMD_BST)) begin
                // no word issued on the cut edge, so the last one
                // leaves cl-1 edges later and float follows
                nxt_rd_on = 1'b0;
                nxt_wr_on = 1'b0;
            end else if (rd_on_ff) begin
                issue = 1'b1;
                nxt_left = left_ff - 4'h1;
                nxt_rd_on = (left_ff != 4'h1);
            end else if (wr_on_ff) begin
                wen = !pin.dqm;
                nxt_left = left_ff - 4'h1;
                nxt_wr_on = (left_ff != 4'h1);
            end
            // sequential wrap inside the burst
            nxt_col = {ucol[sdl_pkg::COL_W-1:sdl_pkg::BLW],
                       ucol[sdl_pkg::BLW-1:0] + 2'h1};
            // word issued at edge 0 exits at edge cl
            for (int k = sdl_pkg::CL_MAX - 1; k > 0; k--) begin
                nxt_pv[k] = pv_ff[k-1];
                nxt_pd[k] = pd_ff[k-1];
            end
            nxt_pv[0] = issue;
            nxt_pd[0] = mem[ucol];
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_ff <= 1'b1;
            rd_on_ff <= 1'b0;
            wr_on_ff <= 1'b0;
            col_ff <= '0;
            left_ff <= '0;
            pv_ff <= '0;
            for (int k = 0; k < sdl_pkg::CL_MAX; k++) begin
                pd_ff[k] <= '0;
            end
            dqm_sh_ff <= '0;
            dq_ff <= '0;
            oe_ff <= 1'b0;
        end else begin
            act_ff <= nxt_act;
            rd_on_ff <= nxt_rd_on;
            wr_on_ff <= nxt_wr_on;
            col_ff <= nxt_col;
            left_ff <= nxt_left;
            pv_ff <= nxt_pv;
            pd_ff <= nxt_pd;
            dqm_sh_ff <= nxt_dqm_sh;
            dq_ff <= nxt_dq;
            oe_ff <= nxt_oe;
        end
    end

    // ****************************************************
    // storage
    // ****************************************************
    // cell contents are not reset, as in a real array
    always_ff @(posedge clk_i) begin
        if (wen) begin
            mem[ucol] <= pin.dq;
        end
    end
endmodule

// ---- rtl/sdl_ctl.sv ----
// Purpose: controller end issuing one burst per request
// Assumes: device end on the same clock
// Notes: read bursts land in a two-entry buffer
`timescale 1ns/10ps
module sdl_ctl (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // configuration
    input wire logic cl3_i,
    input wire logic sleep_i,
    // request
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_write_i,
    input wire logic req_ap_i,
    input wire sdl_pkg::sdl_cut_t req_cut_i,
    input wire sdl_pkg::sdl_bix_t req_cut_idx_i,
    input wire sdl_pkg::sdl_col_t req_col_i,
    input wire logic [sdl_pkg::BL*sdl_pkg::DW-1:0] req_wdata_i,
    input wire logic [sdl_pkg::BL-1:0] req_mask_i,
    // read data
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [sdl_pkg::BL*sdl_pkg::DW-1:0] rd_data_o,
    output logic [sdl_pkg::BL-1:0] rd_ok_o,
    // pins
    sdl_if.ctl pin
);
    // ****************************************************
    // state
    // ****************************************************
    sdl_pkg::sdl_cst_t st_ff, nxt_st;
    sdl_pkg::sdl_cnt_t cnt_ff, nxt_cnt, lim_ff, nxt_lim, n, cl;
    logic [2:0] cmd_ff, nxt_cmd;
    logic cs_n_ff, nxt_cs_n, cke_ff, nxt_cke, pre_ff, nxt_pre;
    logic [sdl_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
    logic [sdl_pkg::DW-1:0] dq_ff, nxt_dq;
    logic dqoe_ff, nxt_dqoe, dqm_ff, nxt_dqm;
    logic wr_ff, nxt_wr, ap_ff, nxt_ap;
    sdl_pkg::sdl_cut_t cut_ff, nxt_cut;
    sdl_pkg::sdl_bix_t cidx_ff, nxt_cidx, ix;
    logic [sdl_pkg::BL*sdl_pkg::DW-1:0] wd_ff, nxt_wd, rb_ff, nxt_rb;
    logic [sdl_pkg::BL-1:0] mk_ff, nxt_mk, rok_ff, nxt_rok;
    logic push, pop, full, cut_on;
    logic [sdl_pkg::FW-1:0] fm [sdl_pkg::FIFO_DEPTH];
    logic wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [1:0] fc_ff, nxt_fc;

    assign full = (fc_ff == 2'(sdl_pkg::FIFO_DEPTH));
    assign req_ready_o = (st_ff == sdl_pkg::CS_IDLE) && !sleep_i && !full
        && cke_ff;
    assign {pin.ras_n, pin.cas_n, pin.we_n} = cmd_ff;
    assign pin.cs_n = cs_n_ff;
    assign pin.cke = cke_ff;
    assign pin.addr = addr_ff;
    assign pin.dqm = dqm_ff;
    assign pin.ctl_dq = dq_ff;
    assign pin.ctl_dq_oe = dqoe_ff;

    // ****************************************************
    // sequencer
    // ****************************************************
    always_comb begin
        {nxt_st, nxt_cnt, nxt_lim, nxt_pre} = {st_ff, cnt_ff, lim_ff, pre_ff};
        {nxt_wr, nxt_ap, nxt_cut, nxt_cidx} = {wr_ff, ap_ff, cut_ff, cidx_ff};
        {nxt_wd, nxt_mk, nxt_rb, nxt_rok} = {wd_ff, mk_ff, rb_ff, rok_ff};
        nxt_addr = addr_ff;
        nxt_cmd = sdl_pkg::CMD_NOP;
        nxt_cs_n = 1'b1;
        nxt_cke = cke_ff;
        nxt_dq = dq_ff;
        nxt_dqoe = 1'b0;
        nxt_dqm = 1'b0;
        push = 1'b0;
        cl = sdl_pkg::sdl_cnt_t'(cl3_i ? sdl_pkg::CL3 : sdl_pkg::CL2);
        n = cnt_ff + 4'h1;
        ix = sdl_pkg::sdl_bix_t'(cnt_ff - cl - 4'h1);
        cut_on = (cut_ff != sdl_pkg::CUT_NONE) && (cidx_ff != '0);
        case (st_ff)
            sdl_pkg::CS_IDLE: begin
                nxt_cke = !sleep_i;
                if (req_valid_i && req_ready_o) begin
                    {nxt_wr, nxt_ap, nxt_cut} = {req_write_i, req_ap_i,
                                                 req_cut_i};
                    {nxt_cidx, nxt_wd, nxt_mk} = {req_cut_idx_i,
                                                 req_wdata_i, req_mask_i};
                    nxt_rok = '0;
                    nxt_pre = 1'b0;
                    nxt_cmd = sdl_pkg::CMD_ACT;
                    nxt_cs_n = 1'b0;
                    nxt_addr = sdl_pkg::ADDR_W'(req_col_i);
                    nxt_cnt = '0;
                    nxt_st = sdl_pkg::CS_RCD;
                end
            end
            sdl_pkg::CS_RCD: begin
                nxt_cnt = n;
                if (n >= sdl_pkg::RCD_CYC) begin
                    nxt_cmd = wr_ff ? sdl_pkg::CMD_WR : sdl_pkg::CMD_RD;
                    nxt_cs_n = 1'b0;
                    nxt_addr = sdl_pkg::ADDR_W'(req_col_hold(addr_ff));
                    nxt_addr[sdl_pkg::AP_BIT] = ap_ff;
                    // word 0 rides with the write command
                    nxt_dq = wd_ff[sdl_pkg::DW-1:0];
                    nxt_dqoe = wr_ff;
                    nxt_dqm = mk_ff[0];
                    nxt_cnt = '0;
                    // read: bl+trp, write: bl+1+trp
                    nxt_lim = !ap_ff ? 4'hf : sdl_pkg::sdl_cnt_t'(
                        sdl_pkg::BL + sdl_pkg::RP_CYC + (wr_ff ? 1 : 0));
                    nxt_st = sdl_pkg::CS_BURST;
                end
            end
            default: begin
                // cnt is the edge index from the command edge
                nxt_cnt = n;
                if (!wr_ff && cnt_ff > cl && cnt_ff <= cl + sdl_pkg::BL)
                begin
                    nxt_rb[ix*sdl_pkg::DW +: sdl_pkg::DW] = pin.dq;
                    nxt_rok[ix] = pin.dev_dq_oe;
                end
                if (n < sdl_pkg::BL) begin
                    nxt_dq = wd_ff[n[sdl_pkg::BLW-1:0]*sdl_pkg::DW
                                   +: sdl_pkg::DW];
                    nxt_dqoe = wr_ff && !(cut_on && n >= cidx_ff);
                    nxt_dqm = mk_ff[n[sdl_pkg::BLW-1:0]];
                end
                if (cut_on && n == cidx_ff) begin
                    nxt_cs_n = 1'b0;
                    if (cut_ff == sdl_pkg::CUT_PRE) begin
                        nxt_cmd = sdl_pkg::CMD_PRE;
                        nxt_pre = 1'b1;
                        nxt_lim = n + sdl_pkg::sdl_cnt_t'(sdl_pkg::RP_CYC);
                    end else begin
                        nxt_cmd = sdl_pkg::CMD_BST;
                    end
                end else if (!ap_ff && !pre_ff &&
                             n == (wr_ff ? sdl_pkg::BL + 1 : sdl_pkg::BL))
                begin
                    // write gets one extra edge of recovery
                    nxt_cmd = sdl_pkg::CMD_PRE;
                    nxt_cs_n = 1'b0;
                    nxt_pre = 1'b1;
                    nxt_lim = n + sdl_pkg::sdl_cnt_t'(sdl_pkg::RP_CYC);
                end
                if (cnt_ff >= lim_ff &&
                    (wr_ff || cnt_ff >= cl + sdl_pkg::BL)) begin
                    nxt_cmd = sdl_pkg::CMD_NOP;
                    nxt_cs_n = 1'b1;
                    push = !wr_ff;
                    nxt_st = sdl_pkg::CS_IDLE;
                end
            end
        endcase
    end

    // column kept in addr low bits from the request
    function automatic sdl_pkg::sdl_col_t req_col_hold(
        input logic [sdl_pkg::ADDR_W-1:0] a);
        req_col_hold = a[sdl_pkg::COL_W-1:0];
    endfunction

    // ****************************************************
    // read buffer
    // ****************************************************
    // one entry per burst, so a stalled reader never drops a word
    assign pop = rd_valid_o && rd_ready_i;
    assign rd_valid_o = (fc_ff != 2'h0);
    assign {rd_ok_o, rd_data_o} = fm[rp_ff];

    always_comb begin
        nxt_wp = push ? !wp_ff : wp_ff;
        nxt_rp = pop ? !rp_ff : rp_ff;
        nxt_fc = fc_ff + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {wp_ff, rp_ff, fc_ff} <= '0;
            fm[0] <= '0;
            fm[1] <= '0;
        end else begin
            {wp_ff, rp_ff, fc_ff} <= {nxt_wp, nxt_rp, nxt_fc};
            if (push) begin
                fm[wp_ff] <= {nxt_rok, nxt_rb};
            end
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= sdl_pkg::CS_IDLE;
            {cnt_ff, lim_ff, pre_ff} <= '0;
            cmd_ff <= sdl_pkg::CMD_NOP;
            {cs_n_ff, cke_ff} <= 2'h3;
            {addr_ff, dq_ff, dqoe_ff, dqm_ff} <= '0;
            {wr_ff, ap_ff, cidx_ff, wd_ff, mk_ff} <= '0;
            cut_ff <= sdl_pkg::CUT_NONE;
            {rb_ff, rok_ff} <= '0;
        end else begin
            {st_ff, cnt_ff, lim_ff, pre_ff} <= {nxt_st, nxt_cnt, nxt_lim,
                                                nxt_pre};
            {cmd_ff, cs_n_ff, cke_ff} <= {nxt_cmd, nxt_cs_n, nxt_cke};
            {addr_ff, dq_ff, dqoe_ff, dqm_ff} <= {nxt_addr, nxt_dq,
                                                 nxt_dqoe, nxt_dqm};
            {wr_ff, ap_ff, cut_ff, cidx_ff} <= {nxt_wr, nxt_ap, nxt_cut,
                                               nxt_cidx};
            {wd_ff, mk_ff, rb_ff, rok_ff} <= {nxt_wd, nxt_mk, nxt_rb,
                                             nxt_rok};
        end
    end
endmodule

// ---- testbench/sdl_chk_sva.sv ----
// Purpose: pin-level latency checks between the two ends
// Assumes: one clock; pins as plain inputs
// Notes: a cut parks the read age at 15; later precharges are not cuts
`timescale 1ns/10ps
module sdl_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cl3_i,
    // pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic dqm,
    input wire logic [sdl_pkg::ADDR_W-1:0] addr,
    input wire logic ctl_dq_oe,
    input wire logic [sdl_pkg::DW-1:0] dev_dq,
    input wire logic dev_dq_oe
);
    // ****************************************************
    // decode and read age
    // ****************************************************
    logic [2:0] cmd;
    logic live, is_rd, is_wr, is_pre, is_bst, is_act;
    logic [3:0] age_ff, nxt_age;
    assign cmd = {ras_n, cas_n, we_n};
    assign live = !cs_n && cke;
    assign is_rd = live && cmd == sdl_pkg::CMD_RD;
    assign is_wr = live && cmd == sdl_pkg::CMD_WR;
    assign is_pre = live && cmd == sdl_pkg::CMD_PRE;
    assign is_bst = live && cmd == sdl_pkg::CMD_BST;
    assign is_act = live && cmd == sdl_pkg::CMD_ACT;
    // age at a cut equals its edge index
    always_comb begin
        nxt_age = age_ff;
        if (is_rd) begin
            nxt_age = 4'h1;
        end else if (is_pre || is_bst) begin
            nxt_age = 4'hf;
        end else if (age_ff != 4'hf) begin
            nxt_age = age_ff + 4'h1;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            age_ff <= 4'hf;
        end else begin
            age_ff <= nxt_age;
        end
    end
    // ****************************************************
    // properties
    // ****************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence quiet2;
        !dev_dq_oe [*2];
    endsequence
    sequence last_float;
        dev_dq_oe ##1 !dev_dq_oe;
    endsequence
    property cut_last(trig);
        trig && age_ff >= 4'h1 && age_ff <= 4'h4
            && !(cl3_i ? dqm : $past(dqm))
            |-> if (cl3_i) (##3 last_float) else (##2 last_float);
    endproperty
    property cut_float(trig);
        trig |-> ##3 (cl3_i || !dev_dq_oe) ##1 !dev_dq_oe;
    endproperty
    chk_rd_lat_two: assert property (
        is_rd && !cl3_i && !dqm |-> ##1 quiet2 ##1 dev_dq_oe)
        else $error("read latency 2");
    chk_rd_lat_three: assert property (
        is_rd && cl3_i ##1 !dqm |-> ##1 quiet2 ##1 dev_dq_oe)
        else $error("read latency 3");
    chk_rd_mask_float: assert property (
        dqm |-> ##3 !dev_dq_oe)
        else $error("masked word driven");
    chk_wr_data_lead: assert property (
        is_wr |-> ctl_dq_oe && !dev_dq_oe)
        else $error("write data late");
    chk_pre_float: assert property (
        cut_float(is_pre))
        else $error("late float after precharge");
    chk_bst_float: assert property (
        cut_float(is_bst))
        else $error("late float after burst stop");
    chk_pre_last_word: assert property (
        cut_last(is_pre))
        else $error("last word after precharge");
    chk_bst_last_word: assert property (
        cut_last(is_bst))
        else $error("last word after burst stop");
    chk_cke_freeze: assert property (
        !$past(cke, 2) |-> $stable(dev_dq_oe) && $stable(dev_dq))
        else $error("moved while frozen");
    chk_cmd_cke_up: assert property (
        !cs_n |-> cke && $past(cke))
        else $error("command near low cke");
    // read: the burst cycles only; write: burst plus one recovery cycle
    chk_rd_ap_gap: assert property (
        is_rd && addr[sdl_pkg::AP_BIT] |-> ##1 (!is_act) [*4])
        else $error("early activate, read ap");
    chk_wr_ap_gap: assert property (
        is_wr && addr[sdl_pkg::AP_BIT] |-> ##1 (!is_act) [*5])
        else $error("early activate, write ap");
endmodule

// ---- testbench/sdl_tb.sv ----
// Purpose: drives the controller and judges read data
// Assumes: both ends joined by sdl_if on one clock
// Notes: expected words are what earlier writes left in each column
`timescale 1ns/10ps
module sdl_tb;
    // ****************************************************
    // stimulus and wiring
    // ****************************************************
    localparam logic [63:0] DA = 64'h4444_3333_2222_1111;
    localparam logic [63:0] DB = 64'hd4d4_c3c3_b2b2_a1a1;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cl3_i = 1'b0;
    logic sleep_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic req_write_i = 1'b0;
    logic req_ap_i = 1'b0;
    sdl_pkg::sdl_cut_t req_cut_i = sdl_pkg::CUT_NONE;
    sdl_pkg::sdl_bix_t req_cut_idx_i = '0;
    sdl_pkg::sdl_col_t req_col_i = '0;
    logic [63:0] req_wdata_i = '0;
    logic [3:0] req_mask_i = '0;
    logic rd_ready_i = 1'b0;
    logic req_ready_o;
    logic rd_valid_o;
    logic [63:0] rd_data_o;
    logic [3:0] rd_ok_o;
    int errors = 0;
    int checked = 0;
    sdl_if bus();
    sdl_ctl sdl_ctl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .cl3_i(cl3_i),
        .sleep_i(sleep_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_write_i(req_write_i),
        .req_ap_i(req_ap_i), .req_cut_i(req_cut_i),
        .req_cut_idx_i(req_cut_idx_i), .req_col_i(req_col_i),
        .req_wdata_i(req_wdata_i), .req_mask_i(req_mask_i),
        .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
        .rd_data_o(rd_data_o), .rd_ok_o(rd_ok_o), .pin(bus.ctl));
    sdl_dev sdl_dev_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .cl3_i(cl3_i),
        .pin(bus.dev));
    sdl_chk sdl_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .cl3_i(cl3_i),
        .cke(bus.cke), .cs_n(bus.cs_n), .ras_n(bus.ras_n),
        .cas_n(bus.cas_n), .we_n(bus.we_n), .dqm(bus.dqm), .addr(bus.addr),
        .ctl_dq_oe(bus.ctl_dq_oe), .dev_dq(bus.dev_dq),
        .dev_dq_oe(bus.dev_dq_oe));
    always #12.5 clk_i = ~clk_i;
    // ****************************************************
    // shared tasks
    // ****************************************************
    task automatic finish_test;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cmp_vec(input logic [63:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, exp, input string what);
        cmp_vec(64'(got), 64'(exp), what);
    endtask
    task automatic timeout(input string what);
        errors++;
        $display("Error at %0t: no answer to %s", $time, what);
        finish_test();
    endtask
    // cas latency changes only in reset
    task automatic do_reset(input logic cl);
        rst_n_i = 1'b0;
        cl3_i = cl;
        repeat (2) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
    endtask
    task automatic send(input logic w, ap, input sdl_pkg::sdl_cut_t cut,
            input int idx, col, input logic [63:0] wd, input logic [3:0] m);
        int n = 0;
        req_write_i = w;
        req_ap_i = ap;
        req_cut_i = cut;
        req_cut_idx_i = sdl_pkg::sdl_bix_t'(idx);
        req_col_i = sdl_pkg::sdl_col_t'(col);
        req_wdata_i = wd;
        req_mask_i = m;
        req_valid_i = 1'b1;
        while (req_ready_o !== 1'b1) begin
            if (n++ > 60) timeout("request");
            @(posedge clk_i);
            #1;
        end
        @(posedge clk_i);
        #1 req_valid_i = 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic pop(input logic [63:0] ed, input logic [3:0] eok);
        int n = 0;
        logic [63:0] keep;
        for (int i = 0; i < 4; i++) keep[16*i+:16] = {16{eok[i]}};
        while (rd_valid_o !== 1'b1) begin
            if (n++ > 60) timeout("read");
            @(posedge clk_i);
            #1;
        end
        cmp_vec({60'h0, rd_ok_o}, {60'h0, eok}, "words seen");
        cmp_vec(rd_data_o & keep, ed & keep, "read data");
        rd_ready_i = 1'b1;
        @(posedge clk_i);
        #1 rd_ready_i = 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    // pins settle before the falling edge
    always @(negedge clk_i) begin
        if (rst_n_i && !bus.cs_n && bus.cke
                && {bus.ras_n, bus.cas_n, bus.we_n} == sdl_pkg::CMD_WR) begin
            cmp_bit(bus.ctl_dq_oe, 1'b1, "write data lead");
        end
    end
    // ****************************************************
    // scenarios
    // ****************************************************
    task automatic t_basic(input logic cl);
        do_reset(cl);
        send(1, 0, sdl_pkg::CUT_NONE, 0, 0, DA, 4'h0);
        send(0, 0, sdl_pkg::CUT_NONE, 0, 0, '0, 4'h0);
        pop(DA, 4'hf);
        send(1, 1, sdl_pkg::CUT_NONE, 0, 8, DB, 4'h0);
        send(0, 1, sdl_pkg::CUT_NONE, 0, 8, '0, 4'h0);
        pop(DB, 4'hf);
    endtask
    task automatic t_masks(input logic cl);
        send(1, 0, sdl_pkg::CUT_NONE, 0, 4, DA, 4'h0);
        send(1, 0, sdl_pkg::CUT_NONE, 0, 4, DB, 4'h4);
        send(0, 0, sdl_pkg::CUT_NONE, 0, 4, '0, 4'h0);
        pop({DB[63:48], DA[47:32], DB[31:0]}, 4'hf);
        send(0, 0, sdl_pkg::CUT_NONE, 0, 0, '0, 4'h2);
        pop(DA, cl ? 4'he : 4'hd);
    endtask
    task automatic t_cuts;
        for (int j = 0; j < 2; j++) begin
            for (int k = 1; k < 4; k++) begin
                send(0, 0, j ? sdl_pkg::CUT_BST : sdl_pkg::CUT_PRE, k, 0,
                     '0, 4'h0);
                pop(DA, 4'((1 << k) - 1));
            end
        end
    endtask
    task automatic t_sleep;
        sleep_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1 cmp_bit(bus.cke, 1'b0, "clock enable");
        cmp_bit(req_ready_o, 1'b0, "ready asleep");
        sleep_i = 1'b0;
        send(0, 0, sdl_pkg::CUT_NONE, 0, 0, '0, 4'h0);
        pop(DA, 4'hf);
    endtask
    // stalled reader: buffer fills, requests refused
    task automatic t_buffer;
        send(0, 0, sdl_pkg::CUT_NONE, 0, 0, '0, 4'h0);
        send(0, 0, sdl_pkg::CUT_NONE, 0, 8, '0, 4'h0);
        repeat (20) @(posedge clk_i);
        #1 cmp_bit(req_ready_o, 1'b0, "ready when full");
        pop(DA, 4'hf);
        pop(DB, 4'hf);
        cmp_bit(rd_valid_o, 1'b0, "buffer empty");
    endtask
    initial begin
        t_basic(1'b0);
        t_masks(1'b0);
        t_cuts();
        t_sleep();
        t_buffer();
        t_basic(1'b1);
        t_masks(1'b1);
        t_cuts();
        cmp_vec(64'(sdl_pkg::RP_CYC), 64'(int'($ceil(real'(sdl_pkg::T_RP_NS)
            / sdl_pkg::CLK_PERIOD_NS))), "precharge cycles");
        finish_test();
    end
endmodule
